/* logic/vic_pkg.sv */
// Shared constants of the vectored interrupt controller
package vic_pkg;
   // Sizes
   localparam int NUM_SRC = 54;
   localparam int NUM_GPIO = 19;
   localparam int NUM_EXT = 3;
   localparam int NUM_PRIO = 32;
   localparam int NUM_FAST = 2;
   localparam int SRC_W = 6;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int SLOT_W = 5;
   localparam int SLOT_EN = 6;
   localparam int HI_W = NUM_SRC - DATA_W;
   // Source map of the off-chip lines and the merged pin source
   localparam int EXT_SRC [NUM_EXT] = '{22, 33, 40};
   localparam int GPIO_SRC = 53;
   // Register byte offsets
   localparam logic [ADDR_W-1:0] RAW_LO = 8'h00;
   localparam logic [ADDR_W-1:0] RAW_HI = 8'h04;
   localparam logic [ADDR_W-1:0] EN_LO = 8'h08;
   localparam logic [ADDR_W-1:0] EN_HI = 8'h0c;
   localparam logic [ADDR_W-1:0] SEL_LO = 8'h10;
   localparam logic [ADDR_W-1:0] SEL_HI = 8'h14;
   localparam logic [ADDR_W-1:0] POL_LO = 8'h18;
   localparam logic [ADDR_W-1:0] POL_HI = 8'h1c;
   localparam logic [ADDR_W-1:0] IRQ_VEC = 8'h20;
   localparam logic [ADDR_W-1:0] FAST_VEC = 8'h24;
   localparam logic [ADDR_W-1:0] PRIO_MASK = 8'h28;
   localparam logic [ADDR_W-1:0] GPIO_EN = 8'h2c;
   localparam logic [ADDR_W-1:0] GPIO_EDGE = 8'h30;
   localparam logic [ADDR_W-1:0] GPIO_POL = 8'h34;
   localparam logic [ADDR_W-1:0] GPIO_BOTH = 8'h38;
   localparam logic [ADDR_W-1:0] GPIO_STAT = 8'h3c;
   localparam logic [ADDR_W-1:0] FAST_SLOT0 = 8'h40;
   localparam logic [ADDR_W-1:0] FAST_SLOT1 = 8'h44;
   localparam logic [ADDR_W-1:0] SLOT_BASE = 8'h80;
   // Priority mask fields and reset values
   localparam int FMASK_LSB = 8;
   localparam logic [SRC_W-1:0] MASK_RST = 6'h3f;
   localparam logic [1:0] FMASK_RST = 2'h3;
endpackage : vic_pkg

/* logic/vic_pin_sync.sv */
// Pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ns
module vic_pin_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Raw pins
   input wire logic [WIDTH-1:0] i_pin,
   // Filtered level and edges
   output logic [WIDTH-1:0] o_level,
   output logic [WIDTH-1:0] o_rise,
   output logic [WIDTH-1:0] o_fall
);
   logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, lvl_ff, rise_ff, fall_ff;
   logic [WIDTH-1:0] nxt_lvl, nxt_rise, nxt_fall;

   // First stage feeds only the second
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         nxt_lvl[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : lvl_ff[i];
      end
      nxt_rise = nxt_lvl & ~lvl_ff;
      nxt_fall = ~nxt_lvl & lvl_ff;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         lvl_ff <= '0;
         rise_ff <= '0;
         fall_ff <= '0;
      end else begin
         s1_ff <= i_pin;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         lvl_ff <= nxt_lvl;
         rise_ff <= nxt_rise;
         fall_ff <= nxt_fall;
      end
   end

   assign o_level = lvl_ff;
   assign o_rise = rise_ff;
   assign o_fall = fall_ff;
endmodule : vic_pin_sync

/* logic/vic_top.sv */
// Vectored interrupt controller with APB register access
//
// Overview of operation
// - Up to 54 interrupt sources can each raise a request to the core.
// - Software steers each source to the normal or the fast request output.
// - 32 priority slots pick the vector of the best pending normal source.
// - Two priority slots pick the vector of the best pending fast source.
// - Each internal source is a level input of programmable polarity.
// - Pin sources trigger on high or low level, rising, falling or both edges.
// - Three off-chip lines act as level requests of programmable polarity.
// - Any of 19 general-purpose pins may be used as an interrupt source.
// - A software priority mask suppresses requests of lower priority.
// - Expansion lines 5, 6 and 7 enter as sources 22, 33 and 40.
`timescale 1ns/1ns
module vic_top import vic_pkg::*; #(
   parameter int NSRC = NUM_SRC,
   parameter int NGPIO = NUM_GPIO
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [DATA_W-1:0] i_pwdata,
   output logic [DATA_W-1:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Interrupt inputs
   input wire logic [NSRC-1:0] i_src,
   input wire logic [NUM_EXT-1:0] i_ext,
   input wire logic [NGPIO-1:0] i_gpio,
   // Requests to the core
   output logic o_irq,
   output logic o_fast_interrupt_request
);
   logic [NSRC-1:0] en_ff, nxt_en, sel_ff, nxt_sel, pol_ff, nxt_pol;
   logic [NSRC-1:0] src, act, pend_irq, pend_fast, cov_irq, cov_fast;
   logic [SRC_W-1:0] mask_ff, nxt_mask;
   logic [1:0] fmask_ff, nxt_fmask;
   logic [NGPIO-1:0] gen_ff, nxt_gen, gedge_ff, nxt_gedge;
   logic [NGPIO-1:0] gpol_ff, nxt_gpol, gboth_ff, nxt_gboth;
   logic [NGPIO-1:0] gstat_ff, nxt_gstat, gev, gclr, glvl, grise, gfall;
   logic [NUM_EXT-1:0] ext_lvl;
   logic [SRC_W:0] slot_ff [NUM_PRIO];
   logic [SRC_W:0] nxt_slot [NUM_PRIO];
   logic [SRC_W:0] fslot_ff [NUM_FAST];
   logic [SRC_W:0] nxt_fslot [NUM_FAST];
   logic [SRC_W:0] vec_ff, nxt_vec, fvec_ff, nxt_fvec;
   logic irq_ff, nxt_irq, fast_ff, nxt_fast, gpio_hit;
   logic win_ok, fwin_ok, stray, fstray;
   logic [SRC_W-1:0] win_pri, win_src, fwin_src;
   logic [1:0] fwin_pri;
   logic [DATA_W-1:0] prdata_ff, nxt_prdata, rdata;
   logic hit, wr, setup, rd_stat;

   // Pins and off-chip lines come from outside the clock domain
   vic_pin_sync #(.WIDTH(NGPIO)) u_gpio_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_pin(i_gpio),
      .o_level(glvl),
      .o_rise(grise),
      .o_fall(gfall)
   );
   vic_pin_sync #(.WIDTH(NUM_EXT)) u_ext_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_pin(i_ext),
      .o_level(ext_lvl),
      .o_rise(),
      .o_fall()
   );

   // Pin trigger selection
   always_comb begin
      for (int i = 0; i < NGPIO; i++) begin
         if (gboth_ff[i]) begin
            gev[i] = grise[i] | gfall[i];
         end else begin
            gev[i] = gpol_ff[i] ? gfall[i] : grise[i];
         end
      end
      gclr = rd_stat ? prdata_ff[NGPIO-1:0] : '0;
      // Only bits already reported are cleared, so a new edge is kept
      nxt_gstat = (gstat_ff & ~gclr) | (gev & gedge_ff);
      gpio_hit = |(gen_ff & (gedge_ff & gstat_ff | ~gedge_ff & (glvl ^ gpol_ff)));
   end

   // Source assembly and sense
   always_comb begin
      src = i_src;
      for (int k = 0; k < NUM_EXT; k++) begin
         src[EXT_SRC[k]] = ext_lvl[k];
      end
      src[GPIO_SRC] = gpio_hit;
      act = (src ^ pol_ff) & en_ff;
      pend_irq = act & ~sel_ff;
      pend_fast = act & sel_ff;
   end

   // Normal request arbitration, slot 0 is the highest priority
   always_comb begin
      win_ok = 1'b0;
      win_pri = SRC_W'(NUM_PRIO);
      win_src = '0;
      cov_irq = '0;
      for (int s = NUM_PRIO - 1; s >= 0; s--) begin
         if (slot_ff[s][SLOT_EN] && slot_ff[s][SRC_W-1:0] < SRC_W'(NSRC)) begin
            cov_irq[slot_ff[s][SRC_W-1:0]] = 1'b1;
            if (pend_irq[slot_ff[s][SRC_W-1:0]]) begin
               win_ok = 1'b1;
               win_pri = SRC_W'(s);
               win_src = slot_ff[s][SRC_W-1:0];
            end
         end
      end
      // Sources without a slot rank below every slot
      stray = |(pend_irq & ~cov_irq);
      nxt_irq = (win_ok && win_pri < mask_ff) || (stray && mask_ff > SRC_W'(NUM_PRIO));
      nxt_vec = {win_ok, win_src};
   end

   // Fast request arbitration over two levels
   always_comb begin
      fwin_ok = 1'b0;
      fwin_pri = 2'(NUM_FAST);
      fwin_src = '0;
      cov_fast = '0;
      for (int s = NUM_FAST - 1; s >= 0; s--) begin
         if (fslot_ff[s][SLOT_EN] && fslot_ff[s][SRC_W-1:0] < SRC_W'(NSRC)) begin
            cov_fast[fslot_ff[s][SRC_W-1:0]] = 1'b1;
            if (pend_fast[fslot_ff[s][SRC_W-1:0]]) begin
               fwin_ok = 1'b1;
               fwin_pri = 2'(s);
               fwin_src = fslot_ff[s][SRC_W-1:0];
            end
         end
      end
      fstray = |(pend_fast & ~cov_fast);
      nxt_fast = (fwin_ok && fwin_pri < fmask_ff) || (fstray && fmask_ff > 2'(NUM_FAST));
      nxt_fvec = {fwin_ok, fwin_src};
   end

   // APB decode; zero wait states, data captured in the setup cycle
   assign wr = i_psel & i_penable & i_pwrite;
   assign setup = i_psel & ~i_penable;
   assign rd_stat = i_psel & i_penable & ~i_pwrite & hit & (i_paddr == GPIO_STAT);

   always_comb begin
      hit = 1'b1;
      rdata = '0;
      if (i_paddr >= SLOT_BASE) begin
         hit = (i_paddr[1:0] == 2'b00);
         // A refused slot access reads as zero
         if (hit) begin
            rdata[SRC_W:0] = slot_ff[i_paddr[SLOT_W+1:2]];
         end
      end else begin
         unique case (i_paddr)
            RAW_LO: rdata = src[DATA_W-1:0];
            RAW_HI: rdata[HI_W-1:0] = src[NSRC-1:DATA_W];
            EN_LO: rdata = en_ff[DATA_W-1:0];
            EN_HI: rdata[HI_W-1:0] = en_ff[NSRC-1:DATA_W];
            SEL_LO: rdata = sel_ff[DATA_W-1:0];
            SEL_HI: rdata[HI_W-1:0] = sel_ff[NSRC-1:DATA_W];
            POL_LO: rdata = pol_ff[DATA_W-1:0];
            POL_HI: rdata[HI_W-1:0] = pol_ff[NSRC-1:DATA_W];
            IRQ_VEC: rdata[SRC_W:0] = vec_ff;
            FAST_VEC: rdata[SRC_W:0] = fvec_ff;
            PRIO_MASK: begin
               rdata[SRC_W-1:0] = mask_ff;
               rdata[FMASK_LSB+1:FMASK_LSB] = fmask_ff;
            end
            GPIO_EN: rdata[NGPIO-1:0] = gen_ff;
            GPIO_EDGE: rdata[NGPIO-1:0] = gedge_ff;
            GPIO_POL: rdata[NGPIO-1:0] = gpol_ff;
            GPIO_BOTH: rdata[NGPIO-1:0] = gboth_ff;
            GPIO_STAT: rdata[NGPIO-1:0] = gstat_ff;
            FAST_SLOT0: rdata[SRC_W:0] = fslot_ff[0];
            FAST_SLOT1: rdata[SRC_W:0] = fslot_ff[1];
            default: hit = 1'b0;
         endcase
      end
      nxt_prdata = setup ? rdata : prdata_ff;
   end

   // Configuration writes
   always_comb begin
      nxt_en = en_ff;
      nxt_sel = sel_ff;
      nxt_pol = pol_ff;
      nxt_mask = mask_ff;
      nxt_fmask = fmask_ff;
      nxt_gen = gen_ff;
      nxt_gedge = gedge_ff;
      nxt_gpol = gpol_ff;
      nxt_gboth = gboth_ff;
      nxt_slot = slot_ff;
      nxt_fslot = fslot_ff;
      if (wr && hit) begin
         if (i_paddr >= SLOT_BASE) begin
            nxt_slot[i_paddr[SLOT_W+1:2]] = i_pwdata[SRC_W:0];
         end else begin
            unique case (i_paddr)
               EN_LO: nxt_en[DATA_W-1:0] = i_pwdata;
               EN_HI: nxt_en[NSRC-1:DATA_W] = i_pwdata[HI_W-1:0];
               SEL_LO: nxt_sel[DATA_W-1:0] = i_pwdata;
               SEL_HI: nxt_sel[NSRC-1:DATA_W] = i_pwdata[HI_W-1:0];
               POL_LO: nxt_pol[DATA_W-1:0] = i_pwdata;
               POL_HI: nxt_pol[NSRC-1:DATA_W] = i_pwdata[HI_W-1:0];
               PRIO_MASK: begin
                  nxt_mask = i_pwdata[SRC_W-1:0];
                  nxt_fmask = i_pwdata[FMASK_LSB+1:FMASK_LSB];
               end
               GPIO_EN: nxt_gen = i_pwdata[NGPIO-1:0];
               GPIO_EDGE: nxt_gedge = i_pwdata[NGPIO-1:0];
               GPIO_POL: nxt_gpol = i_pwdata[NGPIO-1:0];
               GPIO_BOTH: nxt_gboth = i_pwdata[NGPIO-1:0];
               FAST_SLOT0: nxt_fslot[0] = i_pwdata[SRC_W:0];
               FAST_SLOT1: nxt_fslot[1] = i_pwdata[SRC_W:0];
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         en_ff <= '0;
         sel_ff <= '0;
         pol_ff <= '0;
         mask_ff <= MASK_RST;
         fmask_ff <= FMASK_RST;
         gen_ff <= '0;
         gedge_ff <= '0;
         gpol_ff <= '0;
         gboth_ff <= '0;
         gstat_ff <= '0;
         slot_ff <= '{default: '0};
         fslot_ff <= '{default: '0};
         vec_ff <= '0;
         fvec_ff <= '0;
         irq_ff <= 1'b0;
         fast_ff <= 1'b0;
         prdata_ff <= '0;
      end else begin
         en_ff <= nxt_en;
         sel_ff <= nxt_sel;
         pol_ff <= nxt_pol;
         mask_ff <= nxt_mask;
         fmask_ff <= nxt_fmask;
         gen_ff <= nxt_gen;
         gedge_ff <= nxt_gedge;
         gpol_ff <= nxt_gpol;
         gboth_ff <= nxt_gboth;
         gstat_ff <= nxt_gstat;
         slot_ff <= nxt_slot;
         fslot_ff <= nxt_fslot;
         vec_ff <= nxt_vec;
         fvec_ff <= nxt_fvec;
         irq_ff <= nxt_irq;
         fast_ff <= nxt_fast;
         prdata_ff <= nxt_prdata;
      end
   end

   // Outputs
   assign o_prdata = prdata_ff;
   assign o_pready = 1'b1;
   assign o_pslverr = i_psel & i_penable & ~hit;
   assign o_irq = irq_ff;
   assign o_fast_interrupt_request = fast_ff;
endmodule : vic_top

/* testbench/vic_top_asserts.sv */
// Port assertions of the interrupt controller
`timescale 1ns/1ns
module vic_top_asserts import vic_pkg::*; #(
   parameter int NSRC = NUM_SRC,
   parameter int NGPIO = NUM_GPIO
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // APB
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [DATA_W-1:0] i_pwdata,
   input wire logic [DATA_W-1:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   // Interrupts
   input wire logic [NSRC-1:0] i_src,
   input wire logic [NUM_EXT-1:0] i_ext,
   input wire logic [NGPIO-1:0] i_gpio,
   input wire logic o_irq,
   input wire logic o_fast_interrupt_request
);
   // Shadows, so no body signal is needed
   logic [DATA_W-1:0] en_lo_ff, sel_lo_ff;
   logic [HI_W-1:0] en_hi_ff, sel_hi_ff;
   logic [9:0] pm_ff;
   wire wr = i_psel && i_penable && i_pwrite;
   wire acc = i_psel && i_penable;
   wire no_en = (en_lo_ff == '0) && (en_hi_ff == '0);
   wire no_sel = (sel_lo_ff == '0) && (sel_hi_ff == '0);
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         en_lo_ff <= '0;
         en_hi_ff <= '0;
         sel_lo_ff <= '0;
         sel_hi_ff <= '0;
         pm_ff <= {FMASK_RST, 2'h0, MASK_RST};
      end else if (wr) begin
         if (i_paddr == EN_LO) en_lo_ff <= i_pwdata;
         if (i_paddr == EN_HI) en_hi_ff <= i_pwdata[HI_W-1:0];
         if (i_paddr == SEL_LO) sel_lo_ff <= i_pwdata;
         if (i_paddr == SEL_HI) sel_hi_ff <= i_pwdata[HI_W-1:0];
         if (i_paddr == PRIO_MASK) pm_ff <= i_pwdata[9:0];
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // Two edges: one for the write, one for the request flop
   sequence s_none_on;
      no_en [*2];
   endsequence
   sequence s_rd_err;
      acc && !i_pwrite && o_pslverr;
   endsequence
   chk_idle_no_irq: assert property (s_none_on |-> !o_irq)
      else $error("irq with no source enabled");
   chk_idle_no_fast: assert property (s_none_on |-> !o_fast_interrupt_request)
      else $error("fast request with no source enabled");
   chk_sel_normal: assert property (no_sel [*2] |-> !o_fast_interrupt_request)
      else $error("fast request with nothing steered fast");
   chk_mask_irq: assert property ((pm_ff[5:0] == '0) [*2] |-> !o_irq)
      else $error("irq passed a zero mask");
   chk_mask_fast: assert property ((pm_ff[9:8] == '0) [*2] |-> !o_fast_interrupt_request)
      else $error("fast request passed a zero mask");
   chk_err_reads_zero: assert property (s_rd_err |-> o_prdata == '0)
      else $error("refused read returned data");
   chk_prdata_holds: assert property (!(i_psel && !i_penable) |=> $stable(o_prdata))
      else $error("read data moved outside setup");
   chk_mapped_no_err: assert property (acc && i_paddr == EN_LO |-> !o_pslverr)
      else $error("error on a mapped register");
endmodule : vic_top_asserts
bind vic_top vic_top_asserts #(.NSRC(NSRC), .NGPIO(NGPIO)) i_vic_top_asserts (
   .i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .i_src(i_src), .i_ext(i_ext),
   .i_gpio(i_gpio), .o_irq(o_irq), .o_fast_interrupt_request(o_fast_interrupt_request));

/* testbench/vic_core_model.sv */
// Core side model that notes the requests it is handed
`timescale 1ns/1ns
module vic_core_model (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Requests
   input wire logic i_irq,
   input wire logic i_fast,
   // Seen flags
   output logic o_saw_irq,
   output logic o_saw_fast
);
   // Sticky, so a short request is not lost
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_saw_irq <= 1'b0;
         o_saw_fast <= 1'b0;
      end else begin
         o_saw_irq <= o_saw_irq | (i_irq === 1'b1);
         o_saw_fast <= o_saw_fast | (i_fast === 1'b1);
      end
   end
endmodule : vic_core_model

/* testbench/vectored_interrupt_controller_bench.sv */
// Self-checking bench of the interrupt controller
`timescale 1ns/1ns
module vectored_interrupt_controller_bench import vic_pkg::*; ();
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, irq, fq, rdy, err, ev, sirq, sfq;
   logic [7:0] pa = '0;
   logic [31:0] pwd = '0, prd, rv, seed = 32'hb856_b44f;
   logic [53:0] src = '0;
   logic [2:0] ext = '0;
   logic [18:0] gp = '0;
   // Edge, polarity, both, active pin level
   logic [3:0] md [5] = '{4'h1, 4'h4, 4'h9, 4'hc, 4'ha};
   int bad_count = 0, compares = 0, idx, p;
   initial forever #50 clk = ~clk;
   vic_top i_vic_top (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy),
      .o_pslverr(err), .i_src(src), .i_ext(ext), .i_gpio(gp), .o_irq(irq),
      .o_fast_interrupt_request(fq));
   vic_core_model i_vic_core_model (.i_clk(clk), .i_rst(rst), .i_irq(irq), .i_fast(fq),
      .o_saw_irq(sirq), .o_saw_fast(sfq));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [31:0] vec(int s);
      return 32'h40 | 32'(s);
   endfunction : vec
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      compares++;
      if (s !== e) begin
         bad_count++;
         $display("[ERR] %s exp %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (rdy !== 1'b1);
      rv = prd;
      ev = err;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask : xfer
   // Waits, then checks fast and normal requests together
   task automatic lvl(int n, logic [1:0] e);
      repeat (n) @(posedge clk);
      chk("fast,irq", {fq, irq}, e);
   endtask : lvl
   // One-hot enable; an index past the sources clears all
   task automatic en(int s);
      xfer(1'b1, EN_LO, s < 32 ? 32'h1 << s : '0);
      xfer(1'b1, EN_HI, s < 32 ? '0 : 32'h1 << (s - 32));
   endtask : en
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      xfer(1'b0, PRIO_MASK, '0);
      chk("mask_rst", rv, 32'h33f);
      xfer(1'b0, 8'h48, '0);
      chk("unmapped", {rv[30:0], ev}, 32'h1);
      for (int i = 0; i < 6; i++) begin
         idx = (i % 2) ? 41 + int'(rnd() % 12) : int'(rnd() % 22);
         en(idx);
         src[idx] <= 1'b1;
         lvl(2, 2'h1);
         src[idx] <= 1'b0;
         lvl(2, 2'h0);
         xfer(1'b1, idx < 32 ? POL_LO : POL_HI, 32'h1 << (idx % 32));
         lvl(2, 2'h1);
         xfer(1'b1, idx < 32 ? POL_LO : POL_HI, '0);
      end
      src[idx] <= 1'b1;
      xfer(1'b1, SEL_HI, 32'h1 << (idx - 32));
      lvl(2, 2'h2);
      xfer(1'b1, SEL_HI, '0);
      $display("done sources");
      xfer(1'b1, PRIO_MASK, 32'h320);
      lvl(2, 2'h0);
      xfer(1'b1, PRIO_MASK, 32'h321);
      lvl(2, 2'h1);
      xfer(1'b1, PRIO_MASK, 32'h300);
      lvl(2, 2'h0);
      xfer(1'b1, 8'hfc, vec(idx));
      xfer(1'b1, PRIO_MASK, 32'h320);
      lvl(2, 2'h1);
      xfer(1'b1, PRIO_MASK, 32'h31f);
      lvl(2, 2'h0);
      xfer(1'b1, PRIO_MASK, 32'h33f);
      xfer(1'b1, EN_LO, 32'h1);
      xfer(1'b1, SLOT_BASE, vec(0));
      src[0] <= 1'b1;
      lvl(2, 2'h1);
      xfer(1'b0, IRQ_VEC, '0);
      chk("irq_vec", rv, vec(0));
      xfer(1'b1, SEL_LO, 32'h1);
      xfer(1'b1, FAST_SLOT1, vec(0));
      lvl(2, 2'h3);
      xfer(1'b0, FAST_VEC, '0);
      chk("fast_vec", rv, vec(0));
      xfer(1'b1, SEL_HI, 32'h1 << (idx - 32));
      xfer(1'b1, FAST_SLOT0, vec(idx));
      xfer(1'b0, FAST_VEC, '0);
      chk("fast_best", rv, vec(idx));
      xfer(1'b1, SEL_HI, '0);
      xfer(1'b1, PRIO_MASK, 32'h3f);
      lvl(2, 2'h1);
      src <= '0;
      en(99);
      xfer(1'b1, SEL_LO, '0);
      xfer(1'b1, PRIO_MASK, 32'h33f);
      lvl(2, 2'h0);
      $display("done priority");
      for (int k = 0; k < 3; k++) begin
         en(EXT_SRC[k]);
         ext[k] <= 1'b1;
         lvl(8, 2'h1);
         xfer(1'b0, EXT_SRC[k] < 32 ? RAW_LO : RAW_HI, '0);
         chk("raw", rv, 32'h1 << (EXT_SRC[k] % 32));
         ext[k] <= 1'b0;
         lvl(8, 2'h0);
      end
      $display("done off-chip");
      en(GPIO_SRC);
      for (int m = 0; m < 5; m++) begin
         p = int'(rnd() % 19);
         // Last pin would fire on the new idle level
         xfer(1'b1, GPIO_EN, '0);
         gp <= md[m][0] ? '0 : '1;
         lvl(8, 2'h0);
         xfer(1'b1, GPIO_EN, 32'h1 << p);
         xfer(1'b1, GPIO_EDGE, 32'(md[m][3]) << p);
         xfer(1'b1, GPIO_POL, 32'(md[m][2]) << p);
         xfer(1'b1, GPIO_BOTH, 32'(md[m][1]) << p);
         xfer(1'b0, GPIO_STAT, '0);
         lvl(8, 2'h0);
         gp[p] <= md[m][0];
         lvl(8, 2'h1);
         if (md[m][3]) begin
            xfer(1'b0, GPIO_STAT, '0);
            chk("pin_stat", rv, 32'h1 << p);
         end else begin
            gp[p] <= ~md[m][0];
         end
         lvl(8, 2'h0);
      end
      $display("done pins");
      chk("core_irq", sirq, 1'b1);
      chk("core_fast", sfq, 1'b1);
      close_out();
   end
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      close_out();
   end
endmodule : vectored_interrupt_controller_bench
